// file: src/module_sideband_control.sv
`timescale 1ns/1ps
`include "module_sideband_regs.svh"
`default_nettype none

// How it works
// - Select low lets the module answer two-wire bus commands.
// - Select high: all bus traffic ignored and no response driven.
// - Select defaults to deselected high when undriven, internal pull-up.
// - Reset low longer than minimum pulse resets all user settings.
// - Reset execution interval timed from the reset release rising edge.
// - Reset done raises attention with data-not-ready cleared.
// - Power-up posts reset-complete attention without any host reset pulse.
// - Low-power request high selects reduced power, low selects normal.
// - Presence reads low when plugged in, high when absent.
// - Attention driven low for operational fault or critical status.
// - Module answers at fixed device address A0h only.
module module_sideband_control
	import module_sideband_pkg::*;
#(
	parameter int MIN_RESET_CYCLES = `MSC_MIN_RESET_CYC,
	parameter int INIT_CYCLES      = `MSC_INIT_CYC
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic busSelectN,
	input  wire logic moduleResetN,
	input  wire logic lowPowerRequest,
	input  wire logic sclIn,
	input  wire logic sdaIn,
	output logic      sdaOut,
	output logic      sdaOe,
	input  wire logic engineSdaLow,
	output logic      busActive,
	output logic      busReadDir,
	output logic      settingsResetN,
	output logic      dataNotReady,
	output logic      lowPowerMode,
	input  wire logic faultEvent,
	input  wire logic attentionClear,
	output logic      attentionOut,
	output logic      attentionOe,
	output logic      presentN
);

	// Two-flop synchronisers; the pulled-up pins reset to their idle level
	logic [1:0] selSync_r, rstSync_r, lpmSync_r, sclSync_r, sdaSync_r;
	logic       sclPrev_r, sdaPrev_r;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			selSync_r <= {2{`MSC_PULLUP_LEVEL}};
			rstSync_r <= {2{`MSC_PULLUP_LEVEL}};
			lpmSync_r <= 2'h0;
			sclSync_r <= 2'h3;
			sdaSync_r <= 2'h3;
			sclPrev_r <= 1'b1;
			sdaPrev_r <= 1'b1;
		end else begin
			selSync_r <= {selSync_r[0], busSelectN};
			rstSync_r <= {rstSync_r[0], moduleResetN};
			lpmSync_r <= {lpmSync_r[0], lowPowerRequest};
			sclSync_r <= {sclSync_r[0], sclIn};
			sdaSync_r <= {sdaSync_r[0], sdaIn};
			sclPrev_r <= sclSync_r[1];
			sdaPrev_r <= sdaSync_r[1];
		end
	end

	logic selected, rstPin, sclS, sdaS;
	assign selected = !selSync_r[1];
	assign rstPin   = rstSync_r[1];
	assign sclS     = sclSync_r[1];
	assign sdaS     = sdaSync_r[1];

	// Reset sequencing
	reset_state_type rstState_r, rstState_nxt;
	logic [15:0]     lowCnt_r, lowCnt_nxt;
	logic [16:0]     initCnt_r, initCnt_nxt;
	logic            attn_r, attn_nxt, initDone;

	always_comb begin
		rstState_nxt = rstState_r;
		lowCnt_nxt   = lowCnt_r;
		initCnt_nxt  = initCnt_r;
		initDone     = 1'b0;
		if (!rstPin) begin
			// Short glitches only count up and are forgotten on release
			if (lowCnt_r < 16'(MIN_RESET_CYCLES))
				lowCnt_nxt = lowCnt_r + 16'h0001;
			else
				rstState_nxt = RST_HOLD;
		end else begin
			lowCnt_nxt = 16'h0000;
		end
		unique case (rstState_r)
			RST_HOLD: begin
				if (rstPin) begin
					rstState_nxt = RST_INIT;
					initCnt_nxt  = 17'h00000;
				end
			end
			RST_INIT: begin
				if (rstState_nxt == RST_INIT) begin
					if (initCnt_r >= 17'(INIT_CYCLES - 1)) begin
						rstState_nxt = RST_READY;
						initDone     = 1'b1;
					end else begin
						initCnt_nxt = initCnt_r + 17'h00001;
					end
				end
			end
			RST_READY: ;
			default: rstState_nxt = RST_HOLD;
		endcase
		// A new event wins over a clear in the same cycle
		attn_nxt = (attn_r && !attentionClear && rstState_nxt != RST_HOLD)
			|| initDone || faultEvent;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rstState_r <= RST_INIT;
			lowCnt_r   <= 16'h0000;
			initCnt_r  <= 17'h00000;
			attn_r     <= 1'b0;
		end else begin
			rstState_r <= rstState_nxt;
			lowCnt_r   <= lowCnt_nxt;
			initCnt_r  <= initCnt_nxt;
			attn_r     <= attn_nxt;
		end
	end

	// Status and level outputs, registered or tied low
	logic notReady_r, settingsRstN_r, lpm_r;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			notReady_r     <= 1'b1;
			settingsRstN_r <= 1'b0;
			lpm_r          <= 1'b0;
		end else begin
			notReady_r     <= rstState_nxt != RST_READY;
			settingsRstN_r <= rstState_nxt != RST_HOLD;
			lpm_r          <= lpmSync_r[1];
		end
	end

	assign dataNotReady   = notReady_r;
	assign settingsResetN = settingsRstN_r;
	assign lowPowerMode   = lpm_r;
	assign attentionOut   = 1'b0;
	assign attentionOe    = attn_r;
	// Grounded inside the module, so it is low whenever powered and plugged
	assign presentN       = 1'b0;

	// Two-wire front end: address filter and gating
	bus_state_type busState_r, busState_nxt;
	logic [7:0]    shift_r, shift_nxt;
	logic [3:0]    bitCnt_r, bitCnt_nxt;
	logic          oe_r, oe_nxt, rw_r, rw_nxt;
	logic          startCond, stopCond, sclRise, sclFall;

	assign startCond = sclS && sclPrev_r && sdaPrev_r && !sdaS;
	assign stopCond  = sclS && sclPrev_r && !sdaPrev_r && sdaS;
	assign sclRise   = sclS && !sclPrev_r;
	assign sclFall   = !sclS && sclPrev_r;

	always_comb begin
		busState_nxt = busState_r;
		shift_nxt    = shift_r;
		bitCnt_nxt   = bitCnt_r;
		rw_nxt       = rw_r;
		if (!selected) begin
			busState_nxt = BUS_IDLE;
		end else if (startCond) begin
			busState_nxt = BUS_ADDR;
			bitCnt_nxt   = 4'h0;
		end else if (stopCond) begin
			busState_nxt = BUS_IDLE;
		end else begin
			unique case (busState_r)
				BUS_ADDR: begin
					if (sclRise && bitCnt_r < `MSC_ADDR_BITS) begin
						shift_nxt  = {shift_r[6:0], sdaS};
						bitCnt_nxt = bitCnt_r + 4'h1;
					end else if (sclFall && bitCnt_r == `MSC_ADDR_BITS) begin
						if (shift_r[7:1] == 7'(`MSC_DEV_ADDR >> 1)) begin
							busState_nxt = BUS_ACK;
							rw_nxt       = shift_r[0];
						end else begin
							busState_nxt = BUS_IGNORE;
						end
					end
				end
				BUS_ACK: if (sclFall) busState_nxt = BUS_DATA;
				BUS_IDLE, BUS_DATA, BUS_IGNORE: ;
				default: busState_nxt = BUS_IDLE;
			endcase
		end
		// Only release-or-pull-low; never drives high on the shared line
		oe_nxt = selected && (busState_nxt == BUS_ACK
			|| (busState_nxt == BUS_DATA && engineSdaLow));
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			busState_r <= BUS_IDLE;
			shift_r    <= 8'h00;
			bitCnt_r   <= 4'h0;
			rw_r       <= 1'b0;
			oe_r       <= 1'b0;
		end else begin
			busState_r <= busState_nxt;
			shift_r    <= shift_nxt;
			bitCnt_r   <= bitCnt_nxt;
			rw_r       <= rw_nxt;
			oe_r       <= oe_nxt;
		end
	end

	assign sdaOut     = 1'b0;
	assign sdaOe      = oe_r;
	assign busActive  = busState_r == BUS_DATA;
	assign busReadDir = rw_r;

	// Checks
	logic [15:0] lowRun_r;
	always_ff @(posedge clk) begin
		if (!resetn)
			lowRun_r <= 16'h0000;
		else if (rstPin)
			lowRun_r <= 16'h0000;
		else if (lowRun_r != 16'hFFFF)
			lowRun_r <= lowRun_r + 16'h0001;
	end

	sel_high_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
		!selected |=> !sdaOe && !busActive) else $error("bus driven while deselected");
	sel_ack_drive_a: assert property (@(posedge clk) disable iff (!resetn)
		busState_r == BUS_ACK |-> sdaOe) else $error("address matched but not acknowledged");
	sel_default_a: assert property (@(posedge clk)
		!resetn |=> !selected) else $error("select not idle after reset");
	short_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
		rstState_r == RST_READY && (rstPin || lowCnt_r < 16'(MIN_RESET_CYCLES))
		|=> rstState_r == RST_READY) else $error("ready lost without a long reset pulse");
	long_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
		!rstPin && lowRun_r == 16'(MIN_RESET_CYCLES + 1) |=> !settingsResetN)
		else $error("long reset pulse not honoured");
	init_start_a: assert property (@(posedge clk) disable iff (!resetn)
		rstState_r == RST_HOLD && rstPin |=> rstState_r == RST_INIT && initCnt_r == 17'h0)
		else $error("init interval not started at release");
	done_attn_a: assert property (@(posedge clk) disable iff (!resetn)
		initDone |=> attentionOe && !dataNotReady) else $error("reset done not posted");
	powerup_post_a: assert property (@(posedge clk)
		!resetn |=> rstState_r == RST_INIT) else $error("power-up does not start init");
	lpm_follow_a: assert property (@(posedge clk) disable iff (!resetn)
		lpmSync_r[1] |=> lowPowerMode) else $error("low-power request not followed");
	present_low_a: assert property (@(posedge clk) presentN == 1'b0)
		else $error("presence not low");
	fault_attn_a: assert property (@(posedge clk) disable iff (!resetn)
		faultEvent |=> attentionOe) else $error("fault not signalled");
	addr_miss_a: assert property (@(posedge clk) disable iff (!resetn)
		busState_r == BUS_ADDR && sclFall && bitCnt_r == `MSC_ADDR_BITS
		&& shift_r[7:1] != 7'h50 && selected && !startCond && !stopCond
		|=> busState_r == BUS_IGNORE) else $error("foreign address acknowledged");

	addr_ack_c: cover property (@(posedge clk) disable iff (!resetn)
		busState_r == BUS_ACK ##1 busState_r == BUS_ACK [*2]);
	host_reset_c: cover property (@(posedge clk) disable iff (!resetn)
		rstState_r == RST_HOLD ##1 rstState_r == RST_INIT);
	ready_attn_c: cover property (@(posedge clk) disable iff (!resetn)
		initDone ##1 attentionOe);

endmodule : module_sideband_control

`default_nettype wire

// file: src/module_sideband_pkg.sv
`default_nettype none
package module_sideband_pkg;

	typedef enum logic [1:0] {
		RST_HOLD  = 2'b00,
		RST_INIT  = 2'b01,
		RST_READY = 2'b10
	} reset_state_type;

	typedef enum logic [2:0] {
		BUS_IDLE   = 3'b000,
		BUS_ADDR   = 3'b001,
		BUS_ACK    = 3'b010,
		BUS_DATA   = 3'b011,
		BUS_IGNORE = 3'b100
	} bus_state_type;

endpackage : module_sideband_pkg

`default_nettype wire

// file: src/module_sideband_regs.svh
`ifndef MODULE_SIDEBAND_REGS_SVH
`define MODULE_SIDEBAND_REGS_SVH

// Two-wire device address, 8-bit form with the direction bit zero
`define MSC_DEV_ADDR        8'hA0
`define MSC_CLK_PERIOD_NS   40
// Shortest reset low pulse that is honoured (least time, rounds up)
`define MSC_MIN_RESET_NS    10000
`define MSC_MIN_RESET_CYC   ((`MSC_MIN_RESET_NS + `MSC_CLK_PERIOD_NS - 1) / `MSC_CLK_PERIOD_NS)
// Reset execution interval from release to ready (longest time, rounds down)
`define MSC_INIT_NS         2000000
`define MSC_INIT_CYC        (`MSC_INIT_NS / `MSC_CLK_PERIOD_NS)
// Undriven level of the pulled-up inputs
`define MSC_PULLUP_LEVEL    1'b1
`define MSC_ADDR_BITS       4'h8

`endif

// file: tb/host_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_board_model (
	input  wire logic clk,
	input  wire logic sdaOe,
	output logic      busSelectN,
	output logic      moduleResetN,
	output logic      lowPowerRequest,
	output logic      sclLine,
	output wire logic sdaLine
);
	logic hostSdaLow;
	// Pulled-up open-drain line: a released line reads high
	assign sdaLine = ~(hostSdaLow | sdaOe);
	initial begin
		busSelectN      = 1'b1;
		moduleResetN    = 1'b1;
		lowPowerRequest = 1'b0;
		sclLine         = 1'b1;
		hostSdaLow      = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge clk);
	endtask : hold
	task automatic setPins(input logic sel, input logic rst, input logic lp);
		busSelectN      = sel;
		moduleResetN    = rst;
		lowPowerRequest = lp;
	endtask : setPins
	// Five-cycle phases so the pin synchronisers see every level
	task automatic sendAddr(input logic [7:0] addr, output logic acked);
		hostSdaLow = 1'b1;
		hold(5);
		sclLine = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			hold(2);
			hostSdaLow = ~addr[i];
			hold(3);
			sclLine = 1'b1;
			hold(5);
			sclLine = 1'b0;
		end
		hold(2);
		hostSdaLow = 1'b0;
		hold(3);
		sclLine = 1'b1;
		hold(4);
		acked = ~sdaLine;
		hold(1);
		sclLine = 1'b0;
		hold(5);
	endtask : sendAddr
	task automatic stopBus();
		hold(2);
		hostSdaLow = 1'b1;
		hold(3);
		sclLine = 1'b1;
		hold(5);
		hostSdaLow = 1'b0;
		hold(5);
	endtask : stopBus
endmodule : host_board_model
`default_nettype wire

// file: tb/module_sideband_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module module_sideband_control_tb;
	localparam int MIN_RST = 20;
	localparam int INIT    = 40;
	logic      clk;
	logic      resetn;
	logic      faultEvent;
	logic      attentionClear;
	logic      engineSdaLow;
	logic      acked;
	int        n;
	int        failCount = 0;
	int        numChecks = 0;
	wire logic busSelectN, moduleResetN, lowPowerRequest, sclLine, sdaLine;
	wire logic sdaOut, sdaOe, busActive, busReadDir, settingsResetN;
	wire logic dataNotReady, lowPowerMode, attentionOut, attentionOe, presentN;

	host_board_model u_host_board_model (.clk(clk), .sdaOe(sdaOe), .busSelectN(busSelectN),
		.moduleResetN(moduleResetN), .lowPowerRequest(lowPowerRequest), .sclLine(sclLine),
		.sdaLine(sdaLine));
	module_sideband_control #(.MIN_RESET_CYCLES(MIN_RST), .INIT_CYCLES(INIT))
		u_module_sideband_control (.clk(clk), .resetn(resetn), .busSelectN(busSelectN),
		.moduleResetN(moduleResetN), .lowPowerRequest(lowPowerRequest), .sclIn(sclLine),
		.sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .engineSdaLow(engineSdaLow),
		.busActive(busActive), .busReadDir(busReadDir), .settingsResetN(settingsResetN),
		.dataNotReady(dataNotReady), .lowPowerMode(lowPowerMode), .faultEvent(faultEvent),
		.attentionClear(attentionClear), .attentionOut(attentionOut),
		.attentionOe(attentionOe), .presentN(presentN));

	task automatic check(input logic got, input logic exp);
		numChecks++;
		if (got !== exp) begin
			failCount++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic wrapUp();
		$display("checks=%0d errors=%0d", numChecks, failCount);
		if (failCount == 0 && numChecks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrapUp
	// Host leaves status alone until the ready attention shows
	task automatic waitAttn(output int cycles);
		cycles = 0;
		while (attentionOe !== 1'b1) begin
			@(negedge clk);
			cycles++;
			if (cycles > INIT + 20) begin
				failCount++;
				wrapUp();
			end
		end
	endtask : waitAttn
	task automatic pulse(input logic ev, input logic clr, input logic exp);
		faultEvent = ev;
		attentionClear = clr;
		@(negedge clk);
		faultEvent = 1'b0;
		attentionClear = 1'b0;
		check(attentionOe, exp);
	endtask : pulse
	task automatic powerUp();
		@(negedge clk);
		check(dataNotReady, 1'b1);
		check(presentN, 1'b0);
		check(attentionOut, 1'b0);
		check(sdaOut, 1'b0);
		waitAttn(n);
		// Waiting starts one cycle after release, so the interval shows as INIT - 1
		check(n >= INIT - 1 && n <= INIT + 2, 1'b1);
		check(dataNotReady, 1'b0);
	endtask : powerUp
	task automatic attnFlags();
		pulse(1'b0, 1'b1, 1'b0);
		pulse(1'b1, 1'b0, 1'b1);
		pulse(1'b0, 1'b1, 1'b0);
		pulse(1'b1, 1'b1, 1'b1);
		pulse(1'b0, 1'b1, 1'b0);
	endtask : attnFlags
	task automatic lowPower();
		for (int v = 1; v >= 0; v--) begin
			u_host_board_model.setPins(1'b1, 1'b1, v[0]);
			@(negedge clk);
			check(lowPowerMode, ~v[0]);
			repeat (3) @(negedge clk);
			check(lowPowerMode, v[0]);
		end
	endtask : lowPower
	task automatic resetShort();
		u_host_board_model.setPins(1'b1, 1'b0, 1'b0);
		repeat (MIN_RST - 4) @(negedge clk);
		u_host_board_model.setPins(1'b1, 1'b1, 1'b0);
		repeat (5) @(negedge clk);
		check(settingsResetN, 1'b1);
		check(dataNotReady, 1'b0);
	endtask : resetShort
	task automatic resetLong();
		pulse(1'b1, 1'b0, 1'b1);
		u_host_board_model.setPins(1'b1, 1'b0, 1'b0);
		repeat (MIN_RST + 6) @(negedge clk);
		check(settingsResetN, 1'b0);
		check(dataNotReady, 1'b1);
		check(attentionOe, 1'b0);
		u_host_board_model.setPins(1'b1, 1'b1, 1'b0);
		repeat (INIT) @(negedge clk);
		check(settingsResetN, 1'b1);
		check(dataNotReady, 1'b1);
		waitAttn(n);
		check(dataNotReady, 1'b0);
	endtask : resetLong
	task automatic busAccess();
		u_host_board_model.setPins(1'b0, 1'b1, 1'b0);
		repeat (3) @(negedge clk);
		for (int i = 0; i < 2; i++) begin
			u_host_board_model.sendAddr(8'hA0 | i[7:0], acked);
			check(acked, 1'b1);
			check(busActive, 1'b1);
			check(busReadDir, i[0]);
			engineSdaLow = 1'b1;
			@(negedge clk);
			check(sdaOe, 1'b1);
			engineSdaLow = 1'b0;
			@(negedge clk);
			check(sdaOe, 1'b0);
			u_host_board_model.stopBus();
			check(busActive, 1'b0);
		end
		// Engine asks to pull low throughout: only a matched data phase may drive
		engineSdaLow = 1'b1;
		u_host_board_model.sendAddr(8'hA2, acked);
		check(acked, 1'b0);
		check(busActive, 1'b0);
		check(sdaOe, 1'b0);
		u_host_board_model.stopBus();
		u_host_board_model.setPins(1'b1, 1'b1, 1'b0);
		repeat (3) @(negedge clk);
		u_host_board_model.sendAddr(8'hA0, acked);
		check(acked, 1'b0);
		check(busActive, 1'b0);
		check(sdaOe, 1'b0);
		u_host_board_model.stopBus();
		engineSdaLow = 1'b0;
	endtask : busAccess

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		resetn = 1'b0;
		faultEvent = 1'b0;
		attentionClear = 1'b0;
		engineSdaLow = 1'b0;
		repeat (10) @(negedge clk);
		resetn = 1'b1;
		powerUp();
		attnFlags();
		lowPower();
		resetShort();
		resetLong();
		busAccess();
		wrapUp();
	end
endmodule : module_sideband_control_tb
`default_nettype wire
